// ---- core/akr_ramp.sv ----
`timescale 1ns/1ps
`default_nettype none
module akr_ramp
   import akr_pkg::*;
(
   input wire logic clk, // clock
   input wire logic rst_b, // synced reset
   akr_ramp_if.eng r // ramp config and output
);
   logic [4:0] div_r;
   logic [15:0] tmr_r;
   logic dir_d_r;
   logic tick;
   logic step_ok;
   logic [32:0] up_sum;
   logic [32:0] dn_dif;
   logic [31:0] acc_nxt;
   logic [15:0] rate_sel;
   logic [15:0] reload;
   // [RULE15] core clock tick
   assign tick = (div_r == AKR_CORE_DIV);
   // [RULE9] per slope interval
   assign step_ok = tick && (tmr_r == 16'h0000);
   // [RULE9] interval of n core ticks: reload n-1, a zero rate steps every tick
   assign rate_sel = r.dir ? r.rate_up : r.rate_dn;
   assign reload = (rate_sel == 16'h0000) ? 16'h0000 : rate_sel - 16'h0001;
   assign up_sum = {1'b0, r.acc} + {1'b0, r.step_up};
   assign dn_dif = {1'b0, r.acc} - {1'b0, r.step_dn};
   // [RULE16] clamp at limits
   always_comb begin
      acc_nxt = r.acc;
      if (r.dir) begin
         if (up_sum[32] || up_sum[31:0] > r.lim_hi) acc_nxt = r.lim_hi;
         else acc_nxt = up_sum[31:0];
      end else begin
         if (dn_dif[32] || dn_dif[31:0] < r.lim_lo) acc_nxt = r.lim_lo;
         else acc_nxt = dn_dif[31:0];
      end
   end
   // [RULE6] timer runs only when enabled
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         div_r <= 5'h00;
         tmr_r <= 16'h0000;
         dir_d_r <= 1'b0;
      end else if (!r.en) begin
         div_r <= 5'h00;
         tmr_r <= 16'h0000;
         dir_d_r <= r.dir;
      end else begin
         dir_d_r <= r.dir;
         div_r <= tick ? 5'h00 : div_r + 5'h01;
         // direction change reloads timer
         if (r.dir != dir_d_r) tmr_r <= reload;
         else if (tick && !r.hold) tmr_r <= (tmr_r == 16'h0000) ? reload : tmr_r - 16'h0001;
      end
   end
   // [RULE17] clear to lower limit; [RULE11] hold freezes; [RULE10] direction
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) r.acc <= 32'h0000_0000;
      else if (!r.en || r.clr) r.acc <= r.lim_lo;
      else if (step_ok && !r.hold) r.acc <= acc_nxt;
   end
   // [RULE16] output in range
   AST_RAMP_LIMITS: assert property (@(posedge clk) disable iff (!rst_b)
      $past(r.en) && r.en && !$past(r.clr) && $past(r.lim_lo) <= $past(r.lim_hi) && $stable(r.lim_lo)
      && $stable(r.lim_hi) && $past(r.acc) >= $past(r.lim_lo) && $past(r.acc) <= $past(r.lim_hi)
      |-> r.acc <= r.lim_hi && r.acc >= r.lim_lo) else $error("ramp left its limits"); // [RULE16]
   AST_RAMP_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
      r.en && !r.clr && r.hold |=> $stable(r.acc) || !$past(r.en)) else $error("ramp moved while held"); // [RULE11]
   AST_RAMP_CLR: assert property (@(posedge clk) disable iff (!rst_b)
      r.clr |=> r.acc == $past(r.lim_lo)) else $error("clear did not load lower limit"); // [RULE17]
   AST_RAMP_DIR: assert property (@(posedge clk) disable iff (!rst_b)
      r.en && !r.clr && !r.dir && $stable(r.dir) |=> r.acc <= $past(r.acc) || $past(r.acc) < $past(r.lim_lo))
      else $error("ramp rose while direction low"); // [RULE10]
   AST_RAMP_TICK: assert property (@(posedge clk) disable iff (!rst_b)
      r.en && !r.clr && !tick |=> $stable(r.acc) || !$past(r.en) || $past(r.clr))
      else $error("ramp stepped between core ticks"); // [RULE15]
endmodule
`default_nettype wire

// ---- core/akr_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module akr_sync
   import akr_pkg::*;
#(
   parameter int W = 1
) (
   input wire logic clk, // clock
   input wire logic rst_b, // reset
   input wire logic [W-1:0] d, // async input
   output logic [W-1:0] q // synchronised
);
   logic [W-1:0] s1_r;
   // two stage synchroniser
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         s1_r <= '0;
         q <= '0;
      end else begin
         s1_r <= d;
         q <= s1_r;
      end
   end
endmodule
`default_nettype wire

// ---- core/akr_top.sv ----
// The implementer's own choices: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module akr_top
   import akr_pkg::*;
(
   input wire logic clk, // 40 MHz clock
   input wire logic rst_b, // async reset, active low
   input wire logic [7:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [31:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write strobes
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [7:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [31:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready, // read data ready
   input wire logic io_update_pin, // io update pin
   input wire logic amplitude_keying_pin, // keying pin
   input wire logic [2:0] profile_pin, // profile select
   input wire logic ramp_direction_pin, // ramp direction
   input wire logic ramp_hold_pin, // ramp hold
   output logic [31:0] ftw_out, // frequency to core
   output logic [15:0] phase_out, // phase to core
   output logic [11:0] amp_out // amplitude to core
);
   logic rs1_r;
   logic rst_s_r;
   logic [31:0] cw1_r;
   logic [31:0] cw2_r;
   logic [31:0] cw1_act_r;
   logic [31:0] cw2_act_r;
   logic [31:0] lim_lo_r;
   logic [31:0] lim_hi_r;
   logic [31:0] step_up_r;
   logic [31:0] step_dn_r;
   logic [31:0] rate_r;
   logic [31:0] prof_r [8];
   logic [31:0] pftw_r [8];
   logic autoclr_r;
   logic [31:0] aw_addr_r;
   logic aw_have_r;
   logic [31:0] wd_r;
   logic [3:0] ws_r;
   logic wd_have_r;
   logic [6:0] pin_s;
   logic upd_d_r;
   logic upd_ev;
   logic sw_upd;
   logic do_wr;
   logic do_rd;
   logic [31:0] rd_mux;
   logic rd_ok;
   logic wr_ok;
   logic key_en;
   logic key_ext;
   logic ramp_en;
   logic [1:0] dest;
   logic [2:0] psel;
   logic [11:0] prof_amp;
   logic [11:0] amp_nxt;
   logic [15:0] ph_nxt;
   logic [31:0] ftw_nxt;
   akr_ramp_if rif ();

   // reset release through two flops
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rs1_r <= 1'b0;
         rst_s_r <= 1'b0;
      end else begin
         rs1_r <= 1'b1;
         rst_s_r <= rs1_r;
      end
   end

   // pin synchronisers
   akr_sync #(.W(7)) u_sync (
      .clk(clk),
      .rst_b(rst_s_r),
      .d({io_update_pin, amplitude_keying_pin, profile_pin, ramp_direction_pin, ramp_hold_pin}),
      .q(pin_s)
   );
   assign psel = pin_s[4:2];

   // byte lane merge
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] st);
      for (int i = 0; i < 4; i++) begin
         if (st[i]) old[8*i +: 8] = nw[8*i +: 8];
      end
      return old;
   endfunction

   // address map check
   function automatic logic hit(input logic [7:0] a, input logic [7:0] base, input logic [7:0] n);
      return (a >= base) && (a < base + 8'(n * 4)) && (a[1:0] == 2'b00);
   endfunction

   // axi write channel decode
   assign do_wr = aw_have_r && wd_have_r && !s_axi_bvalid;
   assign wr_ok = hit(aw_addr_r[7:0], AKR_CW1_OFS, 8'd8) || hit(aw_addr_r[7:0], AKR_PROF_OFS, 8'd16);
   assign sw_upd = do_wr && (aw_addr_r[7:0] == AKR_CMD_OFS) && ws_r[0] && wd_r[0];
   assign upd_ev = (pin_s[6] && !upd_d_r) || sw_upd;

   // axi write handshake
   always_ff @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
         aw_have_r <= 1'b0;
         wd_have_r <= 1'b0;
         aw_addr_r <= 32'h0000_0000;
         wd_r <= 32'h0000_0000;
         ws_r <= 4'h0;
      end else begin
         s_axi_awready <= !aw_have_r && !s_axi_awready;
         s_axi_wready <= !wd_have_r && !s_axi_wready;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            aw_addr_r <= {24'h00_0000, s_axi_awaddr};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wd_have_r <= 1'b1;
            wd_r <= s_axi_wdata;
            ws_r <= s_axi_wstrb;
         end
         if (do_wr) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? 2'b00 : 2'b10;
            aw_have_r <= 1'b0;
            wd_have_r <= 1'b0;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // [RULE13] register file; [RULE18] reset disables ramp and keying
   always_ff @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         cw1_r <= AKR_CW_RST;
         cw2_r <= AKR_CW_RST;
         lim_lo_r <= AKR_CW_RST;
         lim_hi_r <= AKR_CW_RST;
         step_up_r <= AKR_CW_RST;
         step_dn_r <= AKR_CW_RST;
         rate_r <= AKR_CW_RST;
         for (int i = 0; i < 8; i++) begin
            prof_r[i] <= AKR_CW_RST;
            pftw_r[i] <= AKR_CW_RST;
         end
      end else if (do_wr) begin
         case (aw_addr_r[7:0])
            AKR_CW1_OFS: cw1_r <= merge(cw1_r, wd_r, ws_r);
            AKR_CW2_OFS: cw2_r <= merge(cw2_r, wd_r, ws_r);
            AKR_RLIM_LO_OFS: lim_lo_r <= merge(lim_lo_r, wd_r, ws_r);
            AKR_RLIM_HI_OFS: lim_hi_r <= merge(lim_hi_r, wd_r, ws_r);
            AKR_RSTEP_UP_OFS: step_up_r <= merge(step_up_r, wd_r, ws_r);
            AKR_RSTEP_DN_OFS: step_dn_r <= merge(step_dn_r, wd_r, ws_r);
            AKR_RRATE_OFS: rate_r <= merge(rate_r, wd_r, ws_r);
            default: begin
               if (hit(aw_addr_r[7:0], AKR_PROF_OFS, 8'd8))
                  prof_r[aw_addr_r[4:2]] <= merge(prof_r[aw_addr_r[4:2]], wd_r, ws_r);
               if (hit(aw_addr_r[7:0], AKR_PFTW_OFS, 8'd8))
                  pftw_r[aw_addr_r[4:2]] <= merge(pftw_r[aw_addr_r[4:2]], wd_r, ws_r);
            end
         endcase
      end
   end

   // [RULE14] control words take effect at io update
   always_ff @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         cw1_act_r <= AKR_CW_RST;
         cw2_act_r <= AKR_CW_RST;
         upd_d_r <= 1'b0;
         autoclr_r <= 1'b0;
      end else begin
         upd_d_r <= pin_s[6];
         autoclr_r <= upd_ev && cw1_r[AKR_AUTOCLR_BIT];
         if (upd_ev) begin
            cw1_act_r <= cw1_r;
            cw2_act_r <= cw2_r;
         end
      end
   end

   // active control bits
   assign key_en = cw1_act_r[AKR_KEY_EN_BIT];
   assign key_ext = cw1_act_r[AKR_KEY_EXT_BIT];
   assign ramp_en = cw2_act_r[AKR_RAMP_EN_BIT];
   assign dest = cw2_act_r[AKR_DEST_LSB +: 2];

   // ramp engine wiring
   assign rif.en = ramp_en;
   assign rif.clr = cw1_act_r[AKR_CLR_BIT] || autoclr_r;
   assign rif.lim_lo = lim_lo_r;
   assign rif.lim_hi = lim_hi_r;
   assign rif.step_up = step_up_r;
   assign rif.step_dn = step_dn_r;
   assign rif.rate_up = rate_r[15:0];
   assign rif.rate_dn = rate_r[31:16];
   assign rif.dir = pin_s[1];
   assign rif.hold = pin_s[0];
   akr_ramp u_ramp (
      .clk(clk),
      .rst_b(rst_s_r),
      .r(rif)
   );

   // [RULE5] profile scale select
   assign prof_amp = prof_r[psel][31:20];
   // [RULE7] [RULE8] [RULE12] route ramp by destination, rest from profile
   assign ftw_nxt = (ramp_en && dest == 2'b00) ? rif.acc : pftw_r[psel];
   assign ph_nxt = (ramp_en && dest == 2'b01) ? rif.acc[31:16] : prof_r[psel][15:0];
   // [RULE1] [RULE2] [RULE3] [RULE4] keying has amplitude priority
   assign amp_nxt = (key_en && key_ext && !pin_s[5]) ? 12'h000 :
                    key_en ? prof_amp :
                    (ramp_en && dest[1]) ? rif.acc[31:20] : prof_amp;

   // registered core outputs
   always_ff @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         ftw_out <= 32'h0000_0000;
         phase_out <= 16'h0000;
         amp_out <= 12'h000;
      end else begin
         ftw_out <= ftw_nxt;
         phase_out <= ph_nxt;
         amp_out <= amp_nxt;
      end
   end

   // axi read decode
   assign do_rd = s_axi_arvalid && s_axi_arready;
   assign rd_ok = hit(s_axi_araddr, AKR_CW1_OFS, 8'd10) || hit(s_axi_araddr, AKR_PROF_OFS, 8'd16);
   always_comb begin
      rd_mux = 32'h0000_0000;
      case (s_axi_araddr)
         AKR_CW1_OFS: rd_mux = cw1_r;
         AKR_CW2_OFS: rd_mux = cw2_r;
         AKR_RLIM_LO_OFS: rd_mux = lim_lo_r;
         AKR_RLIM_HI_OFS: rd_mux = lim_hi_r;
         AKR_RSTEP_UP_OFS: rd_mux = step_up_r;
         AKR_RSTEP_DN_OFS: rd_mux = step_dn_r;
         AKR_RRATE_OFS: rd_mux = rate_r;
         AKR_STAT_OFS: rd_mux = {25'h000_0000, pin_s};
         AKR_RAMP_OFS: rd_mux = rif.acc;
         default: begin
            if (hit(s_axi_araddr, AKR_PROF_OFS, 8'd8)) rd_mux = prof_r[s_axi_araddr[4:2]];
            else if (hit(s_axi_araddr, AKR_PFTW_OFS, 8'd8)) rd_mux = pftw_r[s_axi_araddr[4:2]];
         end
      endcase
   end

   // axi read handshake
   always_ff @(posedge clk or negedge rst_s_r) begin
      if (!rst_s_r) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= 2'b00;
      end else begin
         // ready from the cycle after no read answer is pending, whatever arvalid does
         s_axi_arready <= !s_axi_rvalid && !do_rd;
         if (do_rd) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_mux;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            s_axi_arready <= 1'b0;
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   AST_KEY_ZERO: assert property (@(posedge clk) disable iff (!rst_s_r)
      key_en && key_ext && !pin_s[5] |=> amp_out == 12'h000) else $error("keying pin low did not zero"); // [RULE3]
   AST_KEY_PRIO: assert property (@(posedge clk) disable iff (!rst_s_r)
      key_en && !(key_ext && !pin_s[5]) |=> amp_out == $past(prof_amp)) else $error("keying lost priority"); // [RULE1]
   AST_KEY_OFF: assert property (@(posedge clk) disable iff (!rst_s_r)
      !key_en && !(ramp_en && dest[1]) |=> amp_out == $past(prof_amp)) else $error("keying pin not ignored"); // [RULE2]
   AST_DEST_PH: assert property (@(posedge clk) disable iff (!rst_s_r)
      ramp_en && dest == 2'b01 |=> phase_out == $past(rif.acc[31:16])) else $error("phase route wrong"); // [RULE7]
   AST_DEST_FREQ: assert property (@(posedge clk) disable iff (!rst_s_r)
      !(ramp_en && dest == 2'b00) |=> ftw_out == $past(pftw_r[psel])) else $error("frequency not from profile"); // [RULE12]
   AST_UPD_ONLY: assert property (@(posedge clk) disable iff (!rst_s_r)
      !upd_ev |=> $stable(cw2_act_r)) else $error("control changed without update"); // [RULE14]
endmodule
`default_nettype wire

// ---- inc/akr_pkg.sv ----
// Overview of operation
// [RULE1] enabled amplitude keying overrides every other amplitude source, ramp included
// [RULE2] keying enable bit gates all keying inputs; clear means pin ignored
// [RULE3] keying plus external keying with pin low forces amplitude to zero
// [RULE4] external keying with pin high takes scale from selected profile
// [RULE5] profile pins pick one of eight profiles, each with 12-bit scale
// [RULE6] ramp enable gates all ramp inputs and stops the step timer
// [RULE7] destination 00 frequency 31:0, 01 phase 31:18, 1x amplitude 31:20; the code takes phase from 31:16
// [RULE8] ramp output msb-aligned with target; surplus low bits dropped
// [RULE9] upper and lower limits, separate step size and interval per slope
// [RULE10] direction pin low ramps down, high ramps up
// [RULE11] hold pin high freezes ramp; low resumes
// [RULE12] parameters not targeted by ramp come from the active profile
// [RULE13] ramp set by eight control bits, three pins, five 32-bit registers; the code uses five control bits and two pins
// [RULE14] ramp enable and clear bits only act at an io update
// [RULE15] step timer counts on core clock, one twenty-fourth of system clock
// [RULE16] ramp output never above upper or below lower limit while enabled
// [RULE17] clearing the accumulator forces output to the lower limit
// [RULE18] after reset ramp and keying are both disabled
package akr_pkg;
   // register byte offsets
   localparam logic [7:0] AKR_CW1_OFS = 8'h00;
   localparam logic [7:0] AKR_CW2_OFS = 8'h04;
   localparam logic [7:0] AKR_RLIM_LO_OFS = 8'h08;
   localparam logic [7:0] AKR_RLIM_HI_OFS = 8'h0C;
   localparam logic [7:0] AKR_RSTEP_UP_OFS = 8'h10;
   localparam logic [7:0] AKR_RSTEP_DN_OFS = 8'h14;
   localparam logic [7:0] AKR_RRATE_OFS = 8'h18;
   localparam logic [7:0] AKR_CMD_OFS = 8'h1C;
   localparam logic [7:0] AKR_STAT_OFS = 8'h20;
   localparam logic [7:0] AKR_RAMP_OFS = 8'h24;
   localparam logic [7:0] AKR_PROF_OFS = 8'h40; // 8 words: [31:20] scale, [15:0] phase
   localparam logic [7:0] AKR_PFTW_OFS = 8'h60; // 8 words: frequency
   // field positions
   localparam int AKR_KEY_EN_BIT = 8;
   localparam int AKR_KEY_EXT_BIT = 9;
   localparam int AKR_CLR_BIT = 12;
   localparam int AKR_AUTOCLR_BIT = 13;
   localparam int AKR_RAMP_EN_BIT = 19;
   localparam int AKR_DEST_LSB = 20;
   // reset values
   localparam logic [31:0] AKR_CW_RST = 32'h0000_0000;
   // core clock divide
   localparam logic [4:0] AKR_CORE_DIV = 5'h17; // 24 - 1
   typedef enum logic [1:0] {AKR_DIR_DN, AKR_DIR_UP, AKR_DIR_HOLD} akr_dir_t;
endpackage

// ---- inc/akr_ramp_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// ramp configuration and result between top and ramp engine
interface akr_ramp_if;
   logic en;
   logic clr;
   logic [31:0] lim_lo;
   logic [31:0] lim_hi;
   logic [31:0] step_up;
   logic [31:0] step_dn;
   logic [15:0] rate_up;
   logic [15:0] rate_dn;
   logic dir;
   logic hold;
   logic [31:0] acc;
   modport ctl (output en, clr, lim_lo, lim_hi, step_up, step_dn, rate_up, rate_dn, dir, hold, input acc);
   modport eng (input en, clr, lim_lo, lim_hi, step_up, step_dn, rate_up, rate_dn, dir, hold, output acc);
endinterface
`default_nettype wire

// ---- verification/akr_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// host side of the pins: requested levels move onto the pins just after an edge
module akr_host_model (
   input wire logic clk, // clock
   input wire logic rst_b, // reset, active low
   input wire logic [6:0] req, // {update, keying, profile, direction, hold}
   output logic io_update_pin, // io update
   output logic amplitude_keying_pin, // keying pin
   output logic [2:0] profile_pin, // profile select
   output logic ramp_direction_pin, // ramp direction
   output logic ramp_hold_pin // ramp hold
);
   // pins held steady between host requests
   // all seven pins, registered together
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         {io_update_pin, amplitude_keying_pin, profile_pin, ramp_direction_pin, ramp_hold_pin} <= 7'h00;
      end else begin
         {io_update_pin, amplitude_keying_pin, profile_pin, ramp_direction_pin, ramp_hold_pin} <= req;
      end
   end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import akr_pkg::*;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0000_0000;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic [6:0] req = 7'h00;
   logic awready, wready, bvalid, arready, rvalid, upd_p, key_p, dir_p, hold_p;
   logic [1:0] bresp, rresp, rs;
   logic [2:0] prof_p, pk;
   logic [31:0] rdata, rd, ftw, f0, lo, hi, c1, c2;
   logic [15:0] phase;
   logic [11:0] amp;
   logic [11:0] scl [8];
   logic [15:0] ph [8];
   logic [31:0] fq [8];
   int miscompares = 0;
   int total_checks = 0;

   // clock, 25 ns period
   initial forever #12.5 clk = ~clk;

   akr_host_model i_host (.clk(clk), .rst_b(rst_b), .req(req), .io_update_pin(upd_p),
      .amplitude_keying_pin(key_p), .profile_pin(prof_p), .ramp_direction_pin(dir_p), .ramp_hold_pin(hold_p));

   akr_top i_dut (.clk(clk), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .io_update_pin(upd_p),
      .amplitude_keying_pin(key_p), .profile_pin(prof_p), .ramp_direction_pin(dir_p),
      .ramp_hold_pin(hold_p), .ftw_out(ftw), .phase_out(phase), .amp_out(amp));

   // verdict and end of run
   task automatic print_verdict();
      if (miscompares == 0 && total_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   // value compare
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // response code compare
   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t resp got=%h exp=%h", $time, got, exp);
      end
   endtask

   // expected amplitude: keying first, then an amplitude ramp, else the profile
   function automatic logic [11:0] exp_amp(logic [31:0] w1, logic [31:0] w2, logic [31:0] acc, logic k,
                                           logic [11:0] s);
      if (w1[AKR_KEY_EN_BIT]) return (w1[AKR_KEY_EXT_BIT] && !k) ? 12'h000 : s;
      if (w2[AKR_RAMP_EN_BIT] && w2[AKR_DEST_LSB+1]) return acc[31:20];
      return s;
   endfunction

   // expected phase: ramp top bits when the ramp targets phase
   function automatic logic [15:0] exp_ph(logic [31:0] w2, logic [31:0] acc, logic [15:0] p);
      return (w2[AKR_RAMP_EN_BIT] && w2[AKR_DEST_LSB+1 -: 2] == 2'b01) ? acc[31:16] : p;
   endfunction

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   // write: address and data offered together, each released when taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (!(bvalid === 1'b1) && n < 200);
      bready <= 1'b0;
      rs = bresp;
      if (n >= 200) miscompares++;
   endtask

   // read: address held until taken, data taken with rvalid
   task automatic rd_reg(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(posedge clk);
         n++;
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (!(rvalid === 1'b1) && n < 200);
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
      if (n >= 200) miscompares++;
   endtask

   // pin levels, then time for the sync flops and output register
   task automatic pins(input logic k, input logic [2:0] p, input logic dr, input logic h);
      @(posedge clk);
      req <= {1'b0, k, p, dr, h};
      cyc(8);
   endtask

   // io update pulse from the host pin
   task automatic upd();
      @(posedge clk);
      req[6] <= 1'b1;
      cyc(4);
      req[6] <= 1'b0;
      cyc(8);
   endtask

   // hang guard, well beyond the expected run of about 15000 cycles
   initial begin
      cyc(60000);
      miscompares++;
      print_verdict();
   end

   // main sequence
   initial begin
      void'($urandom(32'h1380));
      cyc(6);
      rst_b <= 1'b1;
      cyc(8);
      rd_reg(AKR_CW1_OFS);
      chk(rd, AKR_CW_RST);
      chk_resp(rs, 2'b00);
      rd_reg(AKR_CW2_OFS);
      chk(rd, AKR_CW_RST);
      rd_reg(8'h30);
      chk(rd, 32'h0000_0000);
      chk_resp(rs, 2'b10);
      wr(8'h30, $urandom);
      chk_resp(rs, 2'b10);
      // random profile contents
      for (int p = 0; p < 8; p++) begin
         scl[p] = 12'($urandom);
         ph[p] = 16'($urandom);
         fq[p] = $urandom;
         wr(AKR_PROF_OFS + 8'(4 * p), {scl[p], 4'h0, ph[p]});
         wr(AKR_PFTW_OFS + 8'(4 * p), fq[p]);
      end
      // each profile selected; ramp pins toggled while the ramp is off
      for (int p = 0; p < 8; p++) begin
         pins(1'b1, 3'(p), p[0], p[1]);
         chk(32'(amp), 32'(scl[p]));
         chk(32'(phase), 32'(ph[p]));
         chk(ftw, fq[p]);
         rd_reg(AKR_STAT_OFS);
         chk(rd, {25'h0, 2'b01, 3'(p), p[0], p[1]});
      end
      // keying: every mix of enable, external enable and pin level
      for (int i = 0; i < 8; i++) begin
         pk = 3'($urandom);
         c1 = 32'(i[1:0]) << AKR_KEY_EN_BIT;
         wr(AKR_CW1_OFS, c1);
         upd();
         pins(i[2], pk, 1'b0, 1'b0);
         chk(32'(amp), 32'(exp_amp(c1, 32'h0, 32'h0, i[2], scl[pk])));
      end
      wr(AKR_CW1_OFS, 32'h0);
      upd();
      // ramp limits, slopes and rates
      lo = 32'h1000_0000 | ($urandom & 32'h0000_FFFF);
      hi = 32'hC000_0000 | ($urandom & 32'h0000_FFFF);
      wr(AKR_RLIM_LO_OFS, lo);
      wr(AKR_RLIM_HI_OFS, hi);
      wr(AKR_RSTEP_UP_OFS, 32'h0400_0000);
      wr(AKR_RSTEP_DN_OFS, 32'h0800_0000);
      wr(AKR_RRATE_OFS, 32'h0002_0004);
      pins(1'b0, 3'h5, 1'b0, 1'b0);
      c2 = 32'h1 << AKR_RAMP_EN_BIT;
      wr(AKR_CW2_OFS, c2);
      chk_resp(rs, 2'b00);
      cyc(200);
      chk(ftw, fq[5]);
      upd();
      cyc(100);
      chk(ftw, lo);
      pins(1'b0, 3'h5, 1'b1, 1'b0);
      cyc(100);
      f0 = ftw;
      cyc(960);
      chk(ftw - f0, 32'h2800_0000);
      cyc(5000);
      chk(ftw, hi);
      chk(32'(amp), 32'(scl[5]));
      chk(32'(phase), 32'(ph[5]));
      pins(1'b0, 3'h5, 1'b0, 1'b0);
      cyc(300);
      pins(1'b0, 3'h5, 1'b0, 1'b1);
      f0 = ftw;
      cyc(200);
      chk(ftw, f0);
      chk(32'(f0 < hi && f0 > lo), 32'h1);
      pins(1'b0, 3'h5, 1'b0, 1'b0);
      cyc(2000);
      chk(ftw, lo);
      // clear taken from the upper limit
      pins(1'b0, 3'h5, 1'b1, 1'b0);
      cyc(5000);
      wr(AKR_CW1_OFS, 32'h1 << AKR_CLR_BIT);
      upd();
      chk(ftw, lo);
      cyc(300);
      chk(ftw, lo);
      wr(AKR_CW1_OFS, 32'h0);
      upd();
      cyc(300);
      chk(32'(ftw > lo), 32'h1);
      // destinations with the ramp frozen
      pins(1'b0, 3'h5, 1'b1, 1'b1);
      for (int d = 1; d < 4; d++) begin
         c2 = (32'h1 << AKR_RAMP_EN_BIT) | (32'(d) << AKR_DEST_LSB);
         wr(AKR_CW2_OFS, c2);
         upd();
         rd_reg(AKR_RAMP_OFS);
         chk(32'(phase), 32'(exp_ph(c2, rd, ph[5])));
         chk(32'(amp), 32'(exp_amp(32'h0, c2, rd, 1'b1, scl[5])));
         chk(ftw, fq[5]);
      end
      // autoclear: one-cycle clear, the held ramp then stays at the lower limit
      wr(AKR_CW1_OFS, 32'h1 << AKR_AUTOCLR_BIT);
      upd();
      rd_reg(AKR_RAMP_OFS);
      chk(rd, lo);
      // keying outranks the amplitude ramp; update via the command register
      wr(AKR_CW1_OFS, 32'h1 << AKR_KEY_EN_BIT);
      wr(AKR_CMD_OFS, 32'h1);
      cyc(8);
      chk(32'(amp), 32'(scl[5]));
      print_verdict();
   end
endmodule
`default_nettype wire
